/* dcp_pkg.sv */
// Constants for the DMA channel priority and flag register slice
package dcp_pkg;
  localparam int unsigned        NCH          = 32;
  localparam int unsigned        CH_W         = 5;
  localparam int unsigned        ADDR_W       = 8;
  localparam int unsigned        DATA_W       = 32;
  localparam logic [ADDR_W-1:0]  OFS_PRI_CLR  = 8'h00;
  localparam logic [ADDR_W-1:0]  OFS_URG_SET  = 8'h04;
  localparam logic [ADDR_W-1:0]  OFS_URG_CLR  = 8'h08;
  localparam logic [ADDR_W-1:0]  OFS_BUS_ERR  = 8'h0C;
  localparam logic [ADDR_W-1:0]  OFS_DONE     = 8'h10;
  localparam logic [ADDR_W-1:0]  OFS_ALT_SET  = 8'h14;
  localparam logic [DATA_W-1:0]  RST_WORD     = 32'h00000000;
  localparam logic [NCH-1:0]     RST_CH       = 32'h00000000;
  localparam logic [CH_W-1:0]    RST_IDX      = 5'h00;
  localparam int unsigned        ERR_BIT      = 0;
endpackage : dcp_pkg

/* dcp_top.sv */
// Channel selector, priority, bus-error and completion-flag registers of a DMA
// Summary of operation
// - Write one selects primary structure per channel
// - Written zero leaves selector unchanged
// - Primary phase end flips selector
// - Alternate phase end flips selector back
// - Write one raises channel to high priority
// - Zero to raise register does nothing
// - Reading raise register returns priority
// - Write one to lower register normalises
// - Bit 0 shows pending bus error
// - Write one to bit 0 clears error
// - Completion interrupt sets channel's flag bit
// - Flag bit number equals channel number
// - Flag register read clears its bits
// - Write one selects alternate structure first
// - Basic mode completes after programmed transfers
//
// Design decisions made here: the register offsets and register access over APB.
module dcp_top (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dcp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [dcp_pkg::DATA_W-1:0]  pwdata,
  output logic      [dcp_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Transfer engine events, one-cycle pulses; per channel except the single bus error
  input  wire logic [dcp_pkg::NCH-1:0]     phase_done,
  input  wire logic [dcp_pkg::NCH-1:0]     basic_last_xfer,
  input  wire logic [dcp_pkg::NCH-1:0]     mode_done_irq,
  input  wire logic                        bus_err_evt,
  // Arbitration requests
  input  wire logic [dcp_pkg::NCH-1:0]     chan_req,
  // State towards the engine
  output logic      [dcp_pkg::NCH-1:0]     alt_select,
  output logic      [dcp_pkg::NCH-1:0]     urgency,
  output logic                             bus_fault,
  output logic      [dcp_pkg::NCH-1:0]     cmpl_irq,
  output logic      [dcp_pkg::NCH-1:0]     channel_done_flags,
  output logic                             grant_valid,
  output logic      [dcp_pkg::CH_W-1:0]    grant_chan
);

  logic                        setup_ph;
  logic                        acc_ph;
  logic                        wr_acc;
  logic                        rd_acc;
  logic                        addr_hit;
  logic                        wr_pri_clr;
  logic                        wr_alt_set;
  logic                        wr_urg_set;
  logic                        wr_urg_clr;
  logic                        wr_err;
  logic                        rd_done;
  logic [dcp_pkg::NCH-1:0]     cmpl_evt;
  logic [dcp_pkg::NCH-1:0]     hi_req;
  logic [dcp_pkg::DATA_W-1:0]  next_rdata;
  logic [dcp_pkg::NCH-1:0]     next_sel;
  logic                        next_gvalid;
  logic [dcp_pkg::CH_W-1:0]    next_gchan;

  // Lowest-numbered set bit wins within one priority class
  function automatic logic [dcp_pkg::CH_W-1:0] lowest_idx(
    input logic [dcp_pkg::NCH-1:0] vec
  );
    logic [dcp_pkg::CH_W-1:0] idx;
    idx = dcp_pkg::RST_IDX;
    for (int i = dcp_pkg::NCH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = dcp_pkg::CH_W'(i);
      end
    end
    return idx;
  endfunction : lowest_idx

  assign setup_ph   = psel & ~penable;
  assign acc_ph     = psel & penable;
  assign wr_acc     = acc_ph & pwrite;
  assign rd_acc     = acc_ph & ~pwrite;
  assign addr_hit   = (paddr == dcp_pkg::OFS_PRI_CLR) | (paddr == dcp_pkg::OFS_URG_SET) |
                      (paddr == dcp_pkg::OFS_URG_CLR) | (paddr == dcp_pkg::OFS_BUS_ERR) |
                      (paddr == dcp_pkg::OFS_DONE)    | (paddr == dcp_pkg::OFS_ALT_SET);
  assign wr_pri_clr = wr_acc & (paddr == dcp_pkg::OFS_PRI_CLR);
  assign wr_alt_set = wr_acc & (paddr == dcp_pkg::OFS_ALT_SET);
  assign wr_urg_set = wr_acc & (paddr == dcp_pkg::OFS_URG_SET);
  assign wr_urg_clr = wr_acc & (paddr == dcp_pkg::OFS_URG_CLR);
  assign wr_err     = wr_acc & (paddr == dcp_pkg::OFS_BUS_ERR);
  assign rd_done    = rd_acc & (paddr == dcp_pkg::OFS_DONE);

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = acc_ph;
  assign pslverr = acc_ph & ~addr_hit;

  // Read data is captured in the setup cycle, held through the access cycle
  always_comb begin
    next_rdata = dcp_pkg::RST_WORD;
    case (paddr)
      dcp_pkg::OFS_URG_SET: next_rdata = urgency;
      dcp_pkg::OFS_BUS_ERR: next_rdata[dcp_pkg::ERR_BIT] = bus_fault;
      dcp_pkg::OFS_DONE:    next_rdata = channel_done_flags;
      dcp_pkg::OFS_ALT_SET: next_rdata = alt_select;
      default:              next_rdata = dcp_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= dcp_pkg::RST_WORD;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Selector: software set/clear first, then phase completions flip
  always_comb begin
    next_sel = alt_select;
    if (wr_alt_set) begin
      next_sel = next_sel | pwdata;
    end
    if (wr_pri_clr) begin
      next_sel = next_sel & ~pwdata;
    end
    next_sel = next_sel ^ phase_done;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alt_select <= dcp_pkg::RST_CH;
    end else begin
      alt_select <= next_sel;
    end
  end

  // Priority bits: set register then clear register, ones only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      urgency <= dcp_pkg::RST_CH;
    end else if (wr_urg_set) begin
      urgency <= urgency | pwdata;
    end else if (wr_urg_clr) begin
      urgency <= urgency & ~pwdata;
    end
  end

  // Bus error: a new error in the clearing cycle is kept
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_fault <= 1'b0;
    end else if (bus_err_evt) begin
      bus_fault <= 1'b1;
    end else if (wr_err && pwdata[dcp_pkg::ERR_BIT]) begin
      bus_fault <= 1'b0;
    end
  end

  assign cmpl_evt = basic_last_xfer | mode_done_irq;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmpl_irq <= dcp_pkg::RST_CH;
    end else begin
      cmpl_irq <= cmpl_evt;
    end
  end

  // Only bits actually returned are cleared, so late events survive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channel_done_flags <= dcp_pkg::RST_CH;
    end else if (rd_done) begin
      channel_done_flags <= (channel_done_flags & ~prdata) | cmpl_evt;
    end else begin
      channel_done_flags <= channel_done_flags | cmpl_evt;
    end
  end

  // high class first, then lowest channel
  assign hi_req = chan_req & urgency;

  always_comb begin
    next_gvalid = |chan_req;
    if (|hi_req) begin
      next_gchan = lowest_idx(hi_req);
    end else begin
      next_gchan = lowest_idx(chan_req);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      grant_valid <= 1'b0;
      grant_chan  <= dcp_pkg::RST_IDX;
    end else begin
      grant_valid <= next_gvalid;
      grant_chan  <= next_gchan;
    end
  end

  // One-hot form of the granted channel, read only by the checks below
  logic [dcp_pkg::NCH-1:0]     grant_bit;
  assign grant_bit = {{(dcp_pkg::NCH-1){1'b0}}, 1'b1} << grant_chan;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_primary_force: assert property (
    wr_pri_clr |=> (alt_select & $past(pwdata) & ~$past(phase_done)) == dcp_pkg::RST_CH)
    else $error("primary clear did not select primary");

  a_zero_keeps: assert property (
    (wr_pri_clr && !wr_alt_set && phase_done == dcp_pkg::RST_CH)
    |=> (alt_select & ~$past(pwdata)) == ($past(alt_select) & ~$past(pwdata)))
    else $error("zero write changed selector");

  a_prim_flip: assert property (
    (!wr_pri_clr && !wr_alt_set)
    |=> (alt_select & $past(phase_done & ~alt_select)) == $past(phase_done & ~alt_select))
    else $error("primary phase end did not switch");

  a_alt_flip: assert property (
    (!wr_pri_clr && !wr_alt_set)
    |=> (alt_select & $past(phase_done & alt_select)) == dcp_pkg::RST_CH)
    else $error("alternate phase end did not switch back");

  a_urg_raise: assert property (
    wr_urg_set |=> urgency == ($past(urgency) | $past(pwdata)))
    else $error("priority set wrong");

  a_urg_hold: assert property (
    (!wr_urg_set && !wr_urg_clr) |=> $stable(urgency))
    else $error("priority changed without write");

  a_urg_read: assert property (
    (rd_acc && paddr == dcp_pkg::OFS_URG_SET) |-> prdata == $past(urgency))
    else $error("priority readback wrong");

  a_urg_lower: assert property (
    wr_urg_clr |=> urgency == ($past(urgency) & ~$past(pwdata)))
    else $error("priority clear wrong");

  a_err_read: assert property (
    (rd_acc && paddr == dcp_pkg::OFS_BUS_ERR)
    |-> prdata == {31'h00000000, $past(bus_fault)})
    else $error("bus error readback wrong");

  a_err_clear: assert property (
    (wr_err && pwdata[dcp_pkg::ERR_BIT] && !bus_err_evt) |=> !bus_fault)
    else $error("bus error not cleared");

  a_flag_set: assert property (
    cmpl_evt != dcp_pkg::RST_CH |=> (channel_done_flags & $past(cmpl_evt)) == $past(cmpl_evt))
    else $error("completion flag not set");

  a_flag_read: assert property (
    (rd_done && cmpl_evt == dcp_pkg::RST_CH)
    |=> channel_done_flags == ($past(channel_done_flags) & ~$past(prdata)))
    else $error("flag read did not clear");

  a_basic_irq: assert property (
    basic_last_xfer != dcp_pkg::RST_CH
    |=> (cmpl_irq & $past(basic_last_xfer)) == $past(basic_last_xfer))
    else $error("basic completion missing");

  a_hi_first: assert property (
    (|hi_req) |=> grant_valid && (grant_bit & $past(hi_req)) != dcp_pkg::RST_CH)
    else $error("high priority not granted first");

  a_grant_lowest: assert property (
    (|hi_req) |=> ($past(hi_req) & (grant_bit - 1'b1)) == dcp_pkg::RST_CH)
    else $error("high class grant not lowest channel");

  a_grant_normal: assert property (
    (chan_req != dcp_pkg::RST_CH && !(|hi_req))
    |=> grant_valid && (grant_bit & $past(chan_req)) != dcp_pkg::RST_CH
        && ($past(chan_req) & (grant_bit - 1'b1)) == dcp_pkg::RST_CH)
    else $error("normal class grant wrong");

  a_grant_idle: assert property (
    (chan_req == dcp_pkg::RST_CH) |=> !grant_valid)
    else $error("grant without request");

  a_sel_hold: assert property (
    (!wr_pri_clr && !wr_alt_set && phase_done == dcp_pkg::RST_CH)
    |=> $stable(alt_select))
    else $error("selector changed without cause");

  a_alt_start: assert property (
    (wr_alt_set && phase_done == dcp_pkg::RST_CH)
    |=> (alt_select & $past(pwdata)) == $past(pwdata))
    else $error("selector set did not select alternate");

  a_urg_zero: assert property (
    wr_urg_set
    |=> (urgency & ~$past(pwdata)) == ($past(urgency) & ~$past(pwdata)))
    else $error("zero in priority set changed priority");

  a_urg_clr_zero: assert property (
    wr_urg_clr |=> (urgency & $past(pwdata)) == dcp_pkg::RST_CH)
    else $error("priority clear left channel high");

  a_err_set: assert property (
    bus_err_evt |=> bus_fault)
    else $error("bus error not recorded");

  a_err_hold: assert property (
    (!bus_err_evt && !(wr_err && pwdata[dcp_pkg::ERR_BIT])) |=> $stable(bus_fault))
    else $error("bus error changed without cause");

  a_flag_hold: assert property (
    (!rd_done && cmpl_evt == dcp_pkg::RST_CH) |=> $stable(channel_done_flags))
    else $error("completion flags changed without cause");

  a_flag_chan: assert property (
    cmpl_evt != dcp_pkg::RST_CH
    |=> (channel_done_flags & ~$past(channel_done_flags) & ~$past(cmpl_evt))
        == dcp_pkg::RST_CH)
    else $error("flag set for a channel without event");

  a_done_ro: assert property (
    (wr_acc && paddr == dcp_pkg::OFS_DONE && cmpl_evt == dcp_pkg::RST_CH)
    |=> $stable(channel_done_flags))
    else $error("write changed completion flags");

  a_irq_quiet: assert property (
    (cmpl_evt == dcp_pkg::RST_CH) |=> cmpl_irq == dcp_pkg::RST_CH)
    else $error("completion pulse without event");

  c_flag_read:  cover property (rd_done && channel_done_flags != dcp_pkg::RST_CH);
  c_ping_pong:  cover property (phase_done[0] ##[1:20] phase_done[0]);
  c_err_cycle:  cover property (bus_err_evt ##[1:10] wr_err);
  c_hi_over:    cover property ((|hi_req) && (chan_req & ~urgency) != dcp_pkg::RST_CH);
  c_norm_grant: cover property (chan_req != dcp_pkg::RST_CH && !(|hi_req));

endmodule : dcp_top

/* tb_dcp_top.sv */
// Self-checking testbench for the DMA channel priority and flag registers
module tb_dcp_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] phase_done = 32'h0;
  logic [31:0] basic_last_xfer = 32'h0;
  logic [31:0] mode_done_irq = 32'h0;
  logic        bus_err_evt = 1'b0;
  logic [31:0] chan_req = 32'h0;
  logic [31:0] alt_select;
  logic [31:0] urgency;
  logic        bus_fault;
  logic [31:0] cmpl_irq;
  logic [31:0] channel_done_flags;
  logic        grant_valid;
  logic [4:0]  grant_chan;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          num_checks = 0;

  dcp_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_done(phase_done), .basic_last_xfer(basic_last_xfer),
    .mode_done_irq(mode_done_irq), .bus_err_evt(bus_err_evt), .chan_req(chan_req),
    .alt_select(alt_select), .urgency(urgency), .bus_fault(bus_fault), .cmpl_irq(cmpl_irq),
    .channel_done_flags(channel_done_flags), .grant_valid(grant_valid),
    .grant_chan(grant_chan));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One-cycle event pulses; returns 1 ns after the edge that samples them
  task automatic ev(input logic [31:0] pd, bl, md, input logic be);
    @(posedge core_clk);
    phase_done      <= pd;
    basic_last_xfer <= bl;
    mode_done_irq   <= md;
    bus_err_evt     <= be;
    @(posedge core_clk);
    phase_done      <= 32'h0;
    basic_last_xfer <= 32'h0;
    mode_done_irq   <= 32'h0;
    bus_err_evt     <= 1'b0;
    #1;
  endtask : ev

  task automatic t_select();
    apb(1'b1, dcp_pkg::OFS_ALT_SET, 32'hFFFF0000);
    apb(1'b1, dcp_pkg::OFS_PRI_CLR, 32'h0F000000);
    apb(1'b0, dcp_pkg::OFS_ALT_SET, 32'h0);
    chk(rd, 32'hF0FF0000);
    ev(32'h00000003, 32'h0, 32'h0, 1'b0);
    chk(alt_select, 32'hF0FF0003);
    ev(32'h00010001, 32'h0, 32'h0, 1'b0);
    chk(alt_select, 32'hF0FE0002);
  endtask : t_select

  task automatic t_urgency();
    apb(1'b1, dcp_pkg::OFS_URG_SET, 32'h80000001);
    apb(1'b1, dcp_pkg::OFS_URG_SET, 32'h00000000);
    #1;
    chk(urgency, 32'h80000001);
    apb(1'b1, dcp_pkg::OFS_URG_CLR, 32'h00000001);
    apb(1'b0, dcp_pkg::OFS_URG_SET, 32'h0);
    chk(rd, 32'h80000000);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_urgency

  task automatic t_arbitrate();
    @(posedge core_clk);
    chan_req <= 32'h80000004;
    repeat (2) @(posedge core_clk);
    #1;
    chk({26'h0, grant_valid, grant_chan}, {26'h0, 1'b1, 5'd31});
    @(posedge core_clk);
    chan_req <= 32'h0000000C;
    repeat (2) @(posedge core_clk);
    #1;
    chk({26'h0, grant_valid, grant_chan}, {26'h0, 1'b1, 5'd2});
    @(posedge core_clk);
    chan_req <= 32'h0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, grant_valid}, 32'h0);
  endtask : t_arbitrate

  task automatic t_bus_error();
    ev(32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b0, dcp_pkg::OFS_BUS_ERR, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, dcp_pkg::OFS_BUS_ERR, 32'h0);
    #1;
    chk({31'h0, bus_fault}, 32'h1);
    apb(1'b1, dcp_pkg::OFS_BUS_ERR, 32'h1);
    apb(1'b0, dcp_pkg::OFS_BUS_ERR, 32'h0);
    chk(rd, 32'h0);
  endtask : t_bus_error

  task automatic t_flags();
    ev(32'h0, 32'h00000001, 32'h80000000, 1'b0);
    chk(cmpl_irq, 32'h80000001);
    chk(channel_done_flags, 32'h80000001);
    @(posedge core_clk);
    #1;
    chk(cmpl_irq, 32'h0);
    apb(1'b1, dcp_pkg::OFS_DONE, 32'hFFFFFFFF);
    apb(1'b0, dcp_pkg::OFS_DONE, 32'h0);
    chk(rd, 32'h80000001);
    apb(1'b0, dcp_pkg::OFS_DONE, 32'h0);
    chk(rd, 32'h0);
  endtask : t_flags

  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, dcp_pkg::OFS_DONE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, dcp_pkg::OFS_URG_SET, 32'h0);
    chk(rd, 32'h0);
    t_select();
    t_urgency();
    t_arbitrate();
    t_bus_error();
    t_flags();
    summarize();
  end
endmodule : tb_dcp_top
